// file: rtl/uss_pkg.sv
/*
 * uss_pkg: shared constants, enums and packed structs of the universal shift unit.
 * assumes: one system clock domain; the serial clock pin is sampled, never used as a clock.
 */
package uss_pkg;
   // ---------------------------------------------------------------
   // widths and counts
   // ---------------------------------------------------------------
   localparam int USS_DATA_W = 8;        // shift register width
   localparam int USS_CNT_W = 4;         // edge/bit counter width
   localparam int USS_FIFO_DEPTH = 8;    // received byte queue depth
   localparam logic [3:0] USS_CNT_RST = 4'h0;     // counter value after reset
   localparam logic [3:0] USS_CNT_MAX = 4'hf;     // counter wraps after this value
   localparam logic [7:0] USS_DATA_RST = 8'h00;   // data and buffer after reset
   localparam int USS_SYNC_STAGES = 2;   // pin synchroniser depth
   localparam int USS_BIT_MSB = 7;       // position of the outgoing bit
   // ---------------------------------------------------------------
   // timing: system clock and shortest serial clock periods
   // ---------------------------------------------------------------
   localparam int USS_CLK_NS = 100;                 // system clock period in ns
   localparam int USS_TW_DIV = 16;                  // two-wire: serial clock >= 16 system clocks
   localparam int USS_3W_DIV = 4;                   // three-wire: serial clock >= 4 system clocks
   localparam int USS_MIN_3W_NS = USS_CLK_NS * USS_3W_DIV;   // shortest three-wire period
   localparam int USS_MIN_3W_CYC = (USS_MIN_3W_NS + USS_CLK_NS - 1) / USS_CLK_NS;
   localparam int USS_MIN_TW_NS = USS_CLK_NS * USS_TW_DIV;   // shortest two-wire period
   localparam int USS_MIN_TW_CYC = (USS_MIN_TW_NS + USS_CLK_NS - 1) / USS_CLK_NS;

   // wire mode selection
   typedef enum logic [1:0] {
      USS_WM_NONE = 2'h0,
      USS_WM_THREE = 2'h1,
      USS_WM_TWO = 2'h2,
      USS_WM_TWO_HOLD = 2'h3
   } uss_wire_mode_type;

   // control register image: mode and clock selection plus strobes
   typedef struct packed {
      uss_wire_mode_type wire_mode;     // wire mode, low bit is wire_mode_low_bit
      logic external_clock_select;      // clock from pin (or soft strobe on pin toggle)
      logic edge_polarity_select;       // 0: sample rising, 1: sample falling
      logic soft_count_strobe;          // counts/shifts by software strobe
      logic clock_toggle_strobe;        // toggles the clock pin
   } uss_ctrl_type;

   // status register image
   typedef struct packed {
      logic start_flag;                 // start condition seen (two-wire)
      logic count_overflow_flag;        // counter wrapped
      logic [3:0] count;                // edge/bit counter
   } uss_status_type;
endpackage

// file: rtl/uss_fifo.sv
/*
 * uss_fifo: small synchronous FIFO with valid/ready on both sides.
 * assumes: single clock, synchronous active-high reset.
 */
`timescale 1ns/1ns
module uss_fifo
   import uss_pkg::*;
#(
   parameter int WIDTH = USS_DATA_W,
   parameter int DEPTH = USS_FIFO_DEPTH
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];        // storage
   logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt; // pointers with wrap bit
   logic push, pop;

   // full when pointers differ only in wrap bit
   assign o_in_ready = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
   assign o_out_valid = (wr_r != rd_r);
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_data = mem_r[rd_r[AW-1:0]];

   // next pointers
   always_comb begin
      wr_nxt = wr_r + (AW+1)'(push);
      rd_nxt = rd_r + (AW+1)'(pop);
   end

   // pointers and storage
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
      if (push) begin
         mem_r[wr_r[AW-1:0]] <= i_in_data;
      end
   end
endmodule

// file: rtl/uss_core.sv
/*
 * uss_core: universal shift unit - 8-bit shift register, 4-bit edge counter,
 * output latch, buffer register and received-byte queue.
 * assumes: serial pins are asynchronous and are sampled by i_clock;
 * the processor side is on i_clock and writes by one-cycle strobes.
 */
// Functional notes
// - 8-bit shift register, received bytes buffered in buffer register and queue
// - MSB routed to pin chosen by mode
// - output latch changes opposite to sampling edge
// - serial input always from data input pin
// - readable writable 4-bit counter with overflow
// - shift and count from same clock
// - external clock counts both edges
// - clock from pin, timer, or software
// - two-wire start condition raises request
// - two-wire hold clock low after start/overflow
// - three-wire is SPI mode 0/1, no select
// - eight clocks exchange bytes, overflow marks end
// - master toggles clock by port or strobe
// - mode 0 samples rising, shifts falling
// - mode 1 samples falling, shifts rising
// - overflow after sixteen edges sets flag
// - overflow wakes from idle; two-wire start from all
// - max serial clock fck/16 two-wire, fck/4 three-wire
// - status write with flag clears it, loads count
// - sixteen toggle-and-strobe writes complete a byte
// - slave shifts on master edges, flags end
// - latch open first half, always for internal
// - data write beats a shift in same cycle
// - completed byte copied into buffer register
`timescale 1ns/1ns
module uss_core
   import uss_pkg::*;
#(
   parameter int DATA_W = USS_DATA_W,
   parameter int FIFO_DEPTH = USS_FIFO_DEPTH
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // processor: shift data register
   input wire logic i_data_we,
   input wire logic [7:0] i_data_wdata,
   output logic [7:0] o_shift_data_register,
   output logic [7:0] o_shift_buffer_register,
   // processor: control register
   input wire logic i_ctrl_we,
   input wire uss_ctrl_type i_ctrl_wdata,
   output uss_ctrl_type o_shift_control_register,
   // processor: status register
   input wire logic i_status_we,
   input wire uss_status_type i_status_wdata,
   output uss_status_type o_shift_status_register,
   // processor: port output bit of the clock pin, and its toggle
   input wire logic i_port_toggle,
   // timer zero compare match pulse
   input wire logic i_timer_zero_match,
   // serial pins
   input wire logic i_serial_data_input_pin,
   input wire logic i_shift_clock_pin,
   output logic o_shift_clock_pin,
   output logic o_shift_clock_pin_oe,
   output logic o_data_out_pin,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic i_clock_hold_release,
   // events
   output logic o_overflow_irq,
   output logic o_start_irq,
   output logic o_wake_idle,
   output logic o_wake_any,
   // received byte queue
   output logic o_rx_valid,
   input wire logic i_rx_ready,
   output logic [7:0] o_rx_data,
   output logic o_rx_overrun
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] di_sync_r, di_sync_nxt;    // data input pin, 2 stages
   logic [1:0] ck_sync_r, ck_sync_nxt;    // clock pin, 2 stages
   logic ck_prev_r, ck_prev_nxt;          // last synchronised clock level
   logic di_prev_r, di_prev_nxt;          // last synchronised data level

   // first stage only feeds the second stage
   always_comb begin
      di_sync_nxt = {di_sync_r[0], i_serial_data_input_pin};
      ck_sync_nxt = {ck_sync_r[0], i_shift_clock_pin};
      ck_prev_nxt = ck_sync_r[1];
      di_prev_nxt = di_sync_r[1];
   end

   // synchroniser registers
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         di_sync_r <= 2'h0;
         ck_sync_r <= 2'h0;
         ck_prev_r <= 1'b0;
         di_prev_r <= 1'b0;
      end else begin
         di_sync_r <= di_sync_nxt;
         ck_sync_r <= ck_sync_nxt;
         ck_prev_r <= ck_prev_nxt;
         di_prev_r <= di_prev_nxt;
      end
   end

   // ---------------------------------------------------------------
   // control and clock selection
   // ---------------------------------------------------------------
   uss_ctrl_type ctrl_r, ctrl_nxt;        // stored mode bits and count strobe, toggle strobe reads as zero
   logic pin_level_r, pin_level_nxt;      // driven clock pin level (master)
   logic ck_rise, ck_fall;                // clock pin edges seen on the pin
   logic sample_ev, shift_ev, count_ev;   // shift unit events this cycle
   logic two_wire;
   logic ext_sel, strobe_now;
   logic soft_sel;                        // strobe mode as it stands this cycle

   // an edge shows three clocks late; each pin level must stand two clocks
   assign ck_rise = ck_sync_r[1] && !ck_prev_r;
   assign ck_fall = !ck_sync_r[1] && ck_prev_r;
   assign two_wire = ctrl_r.wire_mode[1];
   assign ext_sel = ctrl_r.external_clock_select;
   assign strobe_now = i_ctrl_we && i_ctrl_wdata.soft_count_strobe;
   // the write that selects strobe counting counts too, so no strobe of a byte is lost
   assign soft_sel = i_ctrl_we ? i_ctrl_wdata.soft_count_strobe : ctrl_r.soft_count_strobe;

   // clock source decode: pin edges, timer match or software strobe
   always_comb begin
      sample_ev = 1'b0;
      shift_ev = 1'b0;
      count_ev = 1'b0;
      if (ext_sel) begin
         // pin edges; polarity picks sampling edge
         sample_ev = ctrl_r.edge_polarity_select ? ck_fall : ck_rise;
         shift_ev = ctrl_r.edge_polarity_select ? ck_rise : ck_fall;
         // both edges count, unless the soft strobe counts instead
         count_ev = soft_sel ? strobe_now : (ck_rise || ck_fall);
      end else begin
         // internal source: sample and shift together, once per event
         sample_ev = soft_sel ? strobe_now : i_timer_zero_match;
         shift_ev = sample_ev;
         count_ev = sample_ev;
      end
   end

   // control register and master clock pin level
   always_comb begin
      ctrl_nxt = ctrl_r;
      pin_level_nxt = pin_level_r;
      if (i_ctrl_we) begin
         ctrl_nxt = i_ctrl_wdata;
         ctrl_nxt.soft_count_strobe = i_ctrl_wdata.soft_count_strobe;
         ctrl_nxt.clock_toggle_strobe = 1'b0; // strobe, not stored
      end
      // toggle by port bit or by strobe bit, not by both in one cycle
      if (i_port_toggle ^ (i_ctrl_we && i_ctrl_wdata.clock_toggle_strobe)) begin
         pin_level_nxt = !pin_level_r;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         ctrl_r <= '0;
         pin_level_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         pin_level_r <= pin_level_nxt;
      end
   end

   // ---------------------------------------------------------------
   // shift register, sampled bit, output latch, buffer
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] shreg_r, shreg_nxt; // shift data register
   logic [DATA_W-1:0] buf_r, buf_nxt;     // shift buffer register
   logic in_bit_r, in_bit_nxt;            // bit caught on the sampling edge
   logic latch_r, latch_nxt;              // output latch
   logic latch_open;
   logic done;                            // counter wraps this cycle

   // the latch closes on the sampling edge and reopens on the shift edge
   logic half_r, half_nxt;                // 1: second half of serial cycle

   assign latch_open = !ext_sel || !half_r;

   always_comb begin
      shreg_nxt = shreg_r;
      in_bit_nxt = in_bit_r;
      half_nxt = half_r;
      if (sample_ev) begin
         in_bit_nxt = di_sync_r[1];
      end
      if (ext_sel) begin
         if (sample_ev) begin
            half_nxt = 1'b1;
         end else if (shift_ev) begin
            half_nxt = 1'b0;
         end
      end else begin
         half_nxt = 1'b0;
      end
      if (i_data_we) begin
         shreg_nxt = i_data_wdata;
      end else if (shift_ev) begin
         // internal source shifts in the bit sampled in the same cycle
         shreg_nxt = {shreg_r[DATA_W-2:0], ext_sel ? in_bit_r : di_sync_r[1]};
      end
      // transparent latch follows the MSB while open
      latch_nxt = latch_open ? shreg_nxt[USS_BIT_MSB] : latch_r;
      buf_nxt = done ? shreg_nxt : buf_r;
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         shreg_r <= USS_DATA_RST;
         buf_r <= USS_DATA_RST;
         in_bit_r <= 1'b0;
         latch_r <= 1'b0;
         half_r <= 1'b0;
      end else begin
         shreg_r <= shreg_nxt;
         buf_r <= buf_nxt;
         in_bit_r <= in_bit_nxt;
         latch_r <= latch_nxt;
         half_r <= half_nxt;
      end
   end

   // ---------------------------------------------------------------
   // counter, overflow and start flags, clock hold
   // ---------------------------------------------------------------
   logic [USS_CNT_W-1:0] cnt_r, cnt_nxt;  // edge/bit counter
   logic ovf_r, ovf_nxt;                  // count_overflow_flag
   logic start_r, start_nxt;              // start condition flag
   logic hold_r, hold_nxt;                // two-wire clock held low
   logic start_cond;

   assign done = count_ev && (cnt_r == USS_CNT_MAX);
   // data falls while the clock is high: start condition
   assign start_cond = two_wire && ck_sync_r[1] && ck_prev_r && di_prev_r && !di_sync_r[1];

   always_comb begin
      cnt_nxt = cnt_r;
      ovf_nxt = ovf_r;
      start_nxt = start_r;
      hold_nxt = hold_r;
      if (i_status_we) begin
         cnt_nxt = i_status_wdata.count;
         if (i_status_wdata.count_overflow_flag) begin
            ovf_nxt = 1'b0;
         end
         if (i_status_wdata.start_flag) begin
            start_nxt = 1'b0;
         end
      end else if (count_ev) begin
         cnt_nxt = cnt_r + 4'h1;
      end
      // set wins over a clear in the same cycle
      if (done) begin
         ovf_nxt = 1'b1;
      end
      if (start_cond) begin
         start_nxt = 1'b1;
      end
      // hold clock low after start or, in hold mode, after overflow
      if (!two_wire || i_clock_hold_release) begin
         hold_nxt = 1'b0;
      end else if (start_cond || (done && ctrl_r.wire_mode == USS_WM_TWO_HOLD)) begin
         hold_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         cnt_r <= USS_CNT_RST;
         ovf_r <= 1'b0;
         start_r <= 1'b0;
         hold_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ovf_r <= ovf_nxt;
         start_r <= start_nxt;
         hold_r <= hold_nxt;
      end
   end

   // ---------------------------------------------------------------
   // received byte queue: completed bytes leave through a FIFO
   // ---------------------------------------------------------------
   logic fifo_in_ready;
   logic overrun_r, overrun_nxt;          // a byte was dropped on a full queue

   uss_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_in_valid(done),
      .o_in_ready(fifo_in_ready),
      .i_in_data(shreg_nxt),
      .o_out_valid(o_rx_valid),
      .i_out_ready(i_rx_ready),
      .o_out_data(o_rx_data)
   );

   // the shift register cannot stall, so a full queue is reported sticky
   always_comb begin
      overrun_nxt = overrun_r || (done && !fifo_in_ready);
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         overrun_r <= 1'b0;
      end else begin
         overrun_r <= overrun_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_shift_data_register = shreg_r;
   assign o_shift_buffer_register = buf_r;
   assign o_shift_control_register = ctrl_r;
   assign o_shift_status_register = '{start_flag: start_r, count_overflow_flag: ovf_r,
                                      count: cnt_r};
   // MSB via the latch to data-out (three-wire) or the data line (two-wire)
   assign o_data_out_pin = (ctrl_r.wire_mode == USS_WM_THREE) ? latch_r : 1'b0;
   assign o_sda_out = 1'b0;
   assign o_sda_oe = two_wire && !latch_r;
   // clock pin: master level, or forced low while holding
   assign o_shift_clock_pin = pin_level_r && !hold_r;
   assign o_shift_clock_pin_oe = hold_r || !ext_sel || ctrl_r.soft_count_strobe;
   assign o_overflow_irq = ovf_r;
   assign o_start_irq = start_r;
   assign o_wake_idle = ovf_r;
   assign o_wake_any = two_wire && start_r;
   assign o_rx_overrun = overrun_r;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);

   sequence s_wrap;
      count_ev && !i_status_we && cnt_r == USS_CNT_MAX;
   endsequence
   chk_wrap_sets_flag: assert property (s_wrap |=> ovf_r && cnt_r == 4'h0)
      else $error("counter wrap did not set flag");
   chk_set_wins: assert property (done |=> ovf_r)
      else $error("overflow lost to a status write");
   chk_write_beats_shift: assert property (i_data_we |=> shreg_r == $past(i_data_wdata))
      else $error("data write lost to shift");
   chk_status_clear: assert property (i_status_we && i_status_wdata.count_overflow_flag
      && !done |=> !ovf_r && cnt_r == $past(i_status_wdata.count))
      else $error("status write did not clear");
   chk_buffer_copy: assert property (done && !i_data_we |=> buf_r == shreg_r)
      else $error("buffer not loaded on completion");
   chk_count_step: assert property (count_ev && !i_status_we |=> cnt_r == $past(cnt_r) + 4'h1)
      else $error("counter did not advance");
   chk_both_edges: assert property (ext_sel && !ctrl_r.soft_count_strobe && (ck_rise || ck_fall)
      && !i_status_we |=> cnt_r != $past(cnt_r))
      else $error("pin edge not counted");
   chk_toggle_pin: assert property (i_ctrl_we && i_ctrl_wdata.clock_toggle_strobe && !i_port_toggle
      |=> pin_level_r != $past(pin_level_r))
      else $error("toggle strobe ignored");
   chk_latch_closed: assert property (ext_sel && half_r && !i_data_we && !shift_ev
      |=> $stable(latch_r))
      else $error("latch changed while closed");
   chk_start_flag: assert property (start_cond |=> start_r)
      else $error("start condition not flagged");
endmodule

// file: tb/uss_far_master.sv
/*
 * uss_far_master: behavioural three-wire master (mode 0) on the far side of the pins.
 * assumes: an 800 ns link clock period; the unit under test is the slave and
 * drives its data output back to us.
 */
`timescale 1ns/1ns
module uss_far_master (
   // serial pins seen from the far side
   output logic o_sck,
   output logic o_mosi,
   input wire logic i_miso
);
   localparam int HALF_NS = 400; // half of the 800 ns link clock
   // clock stands low between frames
   initial begin
      o_sck = 1'b0;
      o_mosi = 1'b0;
   end
   // ------------------------------------------------------------
   // one byte, msb first, exchanged over eight clock pulses
   // ------------------------------------------------------------
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      #13; // keep our edges off the system clock edges
      for (int i = 7; i >= 0; i--) begin
         o_mosi = tx[i]; // set up half a cycle before sampling
         #HALF_NS o_sck = 1'b1;
         // the unit moves its output a few system clocks after our falling
         // edge, so we read a little after the rising edge
         #200 rx[i] = i_miso;
         #200 o_sck = 1'b0;
      end
      #HALF_NS o_mosi = ~o_mosi; // a released line shows the inverse of its last value
   endtask
endmodule

// file: tb/tb_universal_serial_shifter_three_wire.sv
/*
 * tb_universal_serial_shifter_three_wire: self-checking bench of uss_core as a
 * three-wire slave, a software-clocked master and a timer-clocked counter.
 * assumes: uss_far_master on the pins; inputs change at falling clock edges.
 */
`timescale 1ns/1ns
module tb_universal_serial_shifter_three_wire;
   import uss_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] dtx; // byte loaded into the unit
      logic [7:0] mtx; // byte sent by the far master
   } uss_row_type;
   logic i_clock = 1'b0;
   logic i_srst = 1'b1;
   logic i_data_we = 1'b0;
   logic [7:0] i_data_wdata = 8'h00;
   logic i_ctrl_we = 1'b0;
   uss_ctrl_type i_ctrl_wdata = '0;
   logic i_status_we = 1'b0;
   uss_status_type i_status_wdata = '0;
   logic i_port_toggle = 1'b0;
   logic i_timer_zero_match = 1'b0;
   logic i_rx_ready = 1'b0; // drain side stalls until the queue overruns
   logic m_sck, m_mosi, ck_out, ck_oe, do_pin, rx_valid, rx_overrun, irq_ov, wake_i;
   logic [7:0] sdr, sbr, rx_data, got;
   uss_ctrl_type ctrl_q;
   uss_status_type stat_q;
   wire logic ck_wire = ck_oe ? ck_out : m_sck; // whoever drives the clock pin wins
   int fails = 0;
   int n_checks = 0;
   uss_row_type rows [9] = '{'{8'h3c, 8'h00}, '{8'h00, 8'hff}, '{8'hff, 8'ha5},
      '{8'h81, 8'h5a}, '{8'h5a, 8'h01}, '{8'h01, 8'h80}, '{8'h80, 8'h3c},
      '{8'ha5, 8'hc3}, '{8'h69, 8'h96}};
   // ------------------------------------------------------------
   // unit, far side and clock
   // ------------------------------------------------------------
   always #50 i_clock = ~i_clock;
   uss_far_master far_u (.o_sck(m_sck), .o_mosi(m_mosi), .i_miso(do_pin));
   uss_core dut_u (.i_clock(i_clock), .i_srst(i_srst), .i_data_we(i_data_we),
      .i_data_wdata(i_data_wdata), .o_shift_data_register(sdr),
      .o_shift_buffer_register(sbr), .i_ctrl_we(i_ctrl_we), .i_ctrl_wdata(i_ctrl_wdata),
      .o_shift_control_register(ctrl_q), .i_status_we(i_status_we),
      .i_status_wdata(i_status_wdata), .o_shift_status_register(stat_q),
      .i_port_toggle(i_port_toggle), .i_timer_zero_match(i_timer_zero_match),
      .i_serial_data_input_pin(m_mosi), .i_shift_clock_pin(ck_wire),
      .o_shift_clock_pin(ck_out), .o_shift_clock_pin_oe(ck_oe), .o_data_out_pin(do_pin),
      .o_sda_out(), .o_sda_oe(), .i_clock_hold_release(1'b0), .o_overflow_irq(irq_ov),
      .o_start_irq(), .o_wake_idle(wake_i), .o_wake_any(), .o_rx_valid(rx_valid),
      .i_rx_ready(i_rx_ready), .o_rx_data(rx_data), .o_rx_overrun(rx_overrun));
   // ------------------------------------------------------------
   // compare, verdict and processor-side writes
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      if (fails == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one-cycle strobes; the extra edge lets the register update land
   task automatic wr_ctrl(input uss_ctrl_type v);
      @(negedge i_clock);
      i_ctrl_we = 1'b1;
      i_ctrl_wdata = v;
      @(negedge i_clock);
      i_ctrl_we = 1'b0;
      @(negedge i_clock);
   endtask
   task automatic wr_status(input uss_status_type v);
      @(negedge i_clock);
      i_status_we = 1'b1;
      i_status_wdata = v;
      @(negedge i_clock);
      i_status_we = 1'b0;
      @(negedge i_clock);
   endtask
   task automatic pulse(ref logic s);
      @(negedge i_clock);
      s = 1'b1;
      @(negedge i_clock);
      s = 1'b0;
      @(negedge i_clock);
   endtask
   // bounded wait; running out counts as a mismatch and ends the run
   task automatic wait_ovf();
      for (int i = 0; i < 60; i++) begin
         if (stat_q.count_overflow_flag === 1'b1) return;
         @(negedge i_clock);
      end
      fails++;
      results();
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(negedge i_clock);
      i_srst = 1'b0;
      @(negedge i_clock);
      chk("status after reset", 8'(stat_q), 8'h00);
      chk("data after reset", sdr, 8'h00);
      // slave, mode 0: sample rising, shift falling, every edge counted
      wr_ctrl('{USS_WM_THREE, 1'b1, 1'b0, 1'b0, 1'b0});
      chk("ctrl", 8'(ctrl_q), 8'h18);
      chk("slave clock oe", 8'(ck_oe), 8'h00);
      foreach (rows[k]) begin
         wr_status('{1'b0, 1'b1, 4'h0});
         i_data_we = 1'b1;
         i_data_wdata = rows[k].dtx;
         @(negedge i_clock);
         i_data_we = 1'b0;
         far_u.xfer(rows[k].mtx, got);
         wait_ovf();
         chk("slave got", sdr, rows[k].mtx);
         chk("master got", got, rows[k].dtx);
         chk("buffer", sbr, rows[k].mtx);
         chk("count", 8'(stat_q.count), 8'h00);
      end
      // nine bytes into an eight-deep queue: the ninth is refused
      chk("overrun", 8'(rx_overrun), 8'h01);
      for (int k = 0; k < 8; k++) begin
         chk("rx valid", 8'(rx_valid), 8'h01);
         chk("rx data", rx_data, rows[k].mtx);
         i_rx_ready = 1'b1;
         @(negedge i_clock);
         i_rx_ready = 1'b0;
         @(negedge i_clock);
      end
      chk("rx empty", 8'(rx_valid), 8'h00);
      // software master: toggle and count strobe together, sixteen writes
      wr_status('{1'b0, 1'b1, 4'h0});
      chk("status cleared", 8'(stat_q), 8'h00);
      for (int k = 0; k < 16; k++) begin
         wr_ctrl('{USS_WM_THREE, 1'b1, 1'b0, 1'b1, 1'b1});
         if (k == 0) chk("clock pin", 8'(ck_out), 8'h01);
         if (k == 0) chk("master clock oe", 8'(ck_oe), 8'h01);
         repeat (5) @(negedge i_clock);
      end
      wait_ovf();
      chk("strobe count", 8'(stat_q.count), 8'h00);
      pulse(i_port_toggle);
      chk("port toggle", 8'(ck_out), 8'h01);
      // timer clocking from a loaded count: wraps fifteen to zero
      wr_ctrl('{USS_WM_THREE, 1'b0, 1'b0, 1'b0, 1'b0});
      wr_status('{1'b0, 1'b1, 4'he});
      chk("count loaded", 8'(stat_q), 8'h0e);
      pulse(i_timer_zero_match);
      chk("timer count", 8'(stat_q), 8'h0f);
      pulse(i_timer_zero_match);
      chk("wrap", 8'(stat_q), 8'h10);
      chk("overflow irq", 8'(irq_ov), 8'h01);
      chk("wake idle", 8'(wake_i), 8'h01);
      // mid-run reset: flags, counter, mode and overrun return to zero
      @(negedge i_clock);
      i_srst = 1'b1;
      repeat (2) @(negedge i_clock);
      i_srst = 1'b0;
      @(negedge i_clock);
      chk("status after reset 2", 8'(stat_q), 8'h00);
      chk("ctrl after reset", 8'(ctrl_q), 8'h00);
      chk("overrun after reset", 8'(rx_overrun), 8'h00);
      results();
   end
endmodule
